//--- rtl/acgc_config_bank.v
// Wishbone register bank for converter clock, gain and chop configuration.
//
// What this block does
// - Channel enables at bits 9,8, reset enabled.
// - Bit 7 selects clock source, external after reset.
// - Bits 4:2 oversampling code, reset 1024.
// - Bits 1:0 power mode, reset high resolution.
// - Clock word bits 15:10 read zero always.
// - Gain bits 6:4 set second channel gain.
// - Gain bits 2:0 set first channel gain.
// - Words 05h, 07h reserved, zero reset, write zero.
// - Chop bit 8 enables chopping, reset off.
// - Chop word at 06h resets to 0600h.
// - Clock word at 03h resets to 038eh.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "acgc_defines.vh"
module acgc_config_bank (
  input wire i_clk, // System clock, 100 MHz.
  input wire i_rst_n, // Asynchronous reset, active low.
  input wire i_wb_cyc, // Wishbone cycle.
  input wire i_wb_stb, // Wishbone strobe.
  input wire i_wb_we, // Wishbone write enable.
  input wire [5:0] i_wb_adr, // Wishbone byte address.
  input wire [3:0] i_wb_sel, // Wishbone byte selects.
  input wire [31:0] i_wb_dat, // Wishbone write data.
  output reg [31:0] o_wb_dat, // Wishbone read data, registered.
  output reg o_wb_ack, // Wishbone acknowledge, registered.
  output wire o_second_channel_enable, // Second converter enable.
  output wire o_first_channel_enable, // First converter enable.
  output wire o_clock_source_external, // High selects external clock.
  output wire [2:0] o_oversampling_ratio_code, // Oversampling code.
  output wire [1:0] o_power_mode_code, // Power mode code.
  output wire [2:0] o_second_channel_gain_code, // Second channel gain code.
  output wire [2:0] o_first_channel_gain_code, // First channel gain code.
  output wire o_chop_enable, // Global chop enable.
  output wire [3:0] o_chop_delay_code // Chop delay code to sequencer.
);
  wire [15:0] clock_and_channel_config; // Clock word.
  wire [15:0] amplifier_gain_select; // Gain word.
  wire [15:0] spare_word_a; // Reserved word at 05h.
  wire [15:0] chop_config; // Chop word.
  wire [15:0] spare_word_b; // Reserved word at 07h.
  wire req; // A new bus request not yet answered.
  wire wr; // Write strobe for the answered cycle.
  wire [3:0] idx; // Word index from the byte address.
  wire [1:0] be; // Lanes covering the 16-bit data.

  // Ack drops the cycle after it rises, so a held request is answered once.
  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = req & i_wb_we;
  assign idx = i_wb_adr[5:2];
  assign be = i_wb_sel[1:0];

  // Decode one index into a write strobe.
  function hit;
    input [3:0] a;
    input [3:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // Clock word: upper bits masked so they always read zero.
  acgc_word_reg #(.RESET_VALUE(`ACGC_RST_CLOCK), .WRITE_MASK(`ACGC_CLK_WMASK)) u_clock (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(wr & hit(idx, `ACGC_IDX_CLOCK)),
    .i_be(be),
    .i_wdata(i_wb_dat[15:0]),
    .o_q(clock_and_channel_config)
  );

  // Gain word; reserved bits are stored as written, the host keeps them zero.
  acgc_word_reg #(.RESET_VALUE(`ACGC_RST_GAIN), .WRITE_MASK(16'hffff)) u_gain (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(wr & hit(idx, `ACGC_IDX_GAIN)),
    .i_be(be),
    .i_wdata(i_wb_dat[15:0]),
    .o_q(amplifier_gain_select)
  );

  // Reserved word A stays read/write with zero reset.
  acgc_word_reg #(.RESET_VALUE(`ACGC_RST_SPARE), .WRITE_MASK(16'hffff)) u_spare_a (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(wr & hit(idx, `ACGC_IDX_SPARE_A)),
    .i_be(be),
    .i_wdata(i_wb_dat[15:0]),
    .o_q(spare_word_a)
  );

  // Chop word resets with delay 0011b and chopping off.
  acgc_word_reg #(.RESET_VALUE(`ACGC_RST_CHOP), .WRITE_MASK(16'hffff)) u_chop (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(wr & hit(idx, `ACGC_IDX_CHOP)),
    .i_be(be),
    .i_wdata(i_wb_dat[15:0]),
    .o_q(chop_config)
  );

  // Reserved word B is built like word A, read/write with zero reset, and keeps its own value.
  acgc_word_reg #(.RESET_VALUE(`ACGC_RST_SPARE), .WRITE_MASK(16'hffff)) u_spare_b (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(wr & hit(idx, `ACGC_IDX_SPARE_B)),
    .i_be(be),
    .i_wdata(i_wb_dat[15:0]),
    .o_q(spare_word_b)
  );

  // Field outputs straight from the stored words.
  assign o_second_channel_enable = clock_and_channel_config[`ACGC_CLK_SECOND_CHANNEL_ENABLE];
  assign o_first_channel_enable = clock_and_channel_config[`ACGC_CLK_FIRST_CHANNEL_ENABLE];
  assign o_clock_source_external = clock_and_channel_config[`ACGC_CLK_SEL];
  assign o_oversampling_ratio_code =
    clock_and_channel_config[`ACGC_CLK_OSR_HI:`ACGC_CLK_OSR_LO];
  assign o_power_mode_code = clock_and_channel_config[`ACGC_CLK_PWR_HI:`ACGC_CLK_PWR_LO];
  assign o_second_channel_gain_code =
    amplifier_gain_select[`ACGC_GAIN1_HI:`ACGC_GAIN1_LO];
  assign o_first_channel_gain_code = amplifier_gain_select[`ACGC_GAIN0_HI:`ACGC_GAIN0_LO];
  assign o_chop_enable = chop_config[`ACGC_CHOP_EN];
  // The delay meaning lives in the sequencer, so the code passes raw.
  assign o_chop_delay_code = chop_config[`ACGC_CHOP_DLY_HI:`ACGC_CHOP_DLY_LO];

  // Ack one cycle after the request; reads return zero-extended words.
  // Unmapped addresses are still acked and read zero, so the bus never hangs.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= req;
      if (req && !i_wb_we) begin
        if (idx == `ACGC_IDX_CLOCK) begin
          o_wb_dat <= {16'h0000, clock_and_channel_config};
        end else if (idx == `ACGC_IDX_GAIN) begin
          o_wb_dat <= {16'h0000, amplifier_gain_select};
        end else if (idx == `ACGC_IDX_SPARE_A) begin
          o_wb_dat <= {16'h0000, spare_word_a};
        end else if (idx == `ACGC_IDX_CHOP) begin
          o_wb_dat <= {16'h0000, chop_config};
        end else if (idx == `ACGC_IDX_SPARE_B) begin
          o_wb_dat <= {16'h0000, spare_word_b};
        end else begin
          o_wb_dat <= 32'h00000000;
        end
      end
    end
  end
endmodule

//--- inc/acgc_defines.vh
// Register offsets, field positions and reset values of the clock, gain and chop bank.
`ifndef ACGC_DEFINES_VH
`define ACGC_DEFINES_VH
// Register indices as printed; the byte address is four times the index.
`define ACGC_IDX_CLOCK 4'h3
`define ACGC_IDX_GAIN 4'h4
`define ACGC_IDX_SPARE_A 4'h5
`define ACGC_IDX_CHOP 4'h6
`define ACGC_IDX_SPARE_B 4'h7
// Reset values of each word.
`define ACGC_RST_CLOCK 16'h038e
`define ACGC_RST_GAIN 16'h0000
`define ACGC_RST_SPARE 16'h0000
`define ACGC_RST_CHOP 16'h0600
// Clock-configuration fields.
`define ACGC_CLK_SECOND_CHANNEL_ENABLE 9
`define ACGC_CLK_FIRST_CHANNEL_ENABLE 8
`define ACGC_CLK_SEL 7
`define ACGC_CLK_RSV_HI 6
`define ACGC_CLK_RSV_LO 5
`define ACGC_CLK_OSR_HI 4
`define ACGC_CLK_OSR_LO 2
`define ACGC_CLK_PWR_HI 1
`define ACGC_CLK_PWR_LO 0
// Writable mask of the clock word; bits 15:10 are read-only zero.
`define ACGC_CLK_WMASK 16'h03ff
// Gain fields.
`define ACGC_GAIN1_HI 6
`define ACGC_GAIN1_LO 4
`define ACGC_GAIN0_HI 2
`define ACGC_GAIN0_LO 0
// Chop fields.
`define ACGC_CHOP_DLY_HI 12
`define ACGC_CHOP_DLY_LO 9
`define ACGC_CHOP_EN 8
`endif

//--- rtl/acgc_word_reg.v
// One 16-bit read/write configuration word with reset value and write mask.
`timescale 1ns/1ps
module acgc_word_reg #(
  parameter [15:0] RESET_VALUE = 16'h0000,
  parameter [15:0] WRITE_MASK = 16'hffff
) (
  input wire i_clk, // System clock.
  input wire i_rst_n, // Asynchronous reset, active low.
  input wire i_we, // One-cycle write strobe.
  input wire [1:0] i_be, // Byte enables for the two lanes.
  input wire [15:0] i_wdata, // Write data.
  output reg [15:0] o_q // Stored word.
);
  // Masked bits keep their reset value for ever, so read-only bits read constant.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_q <= RESET_VALUE;
    end else if (i_we) begin
      if (i_be[0]) begin
        o_q[7:0] <= (i_wdata[7:0] & WRITE_MASK[7:0]) | (RESET_VALUE[7:0] & ~WRITE_MASK[7:0]);
      end
      if (i_be[1]) begin
        o_q[15:8] <= (i_wdata[15:8] & WRITE_MASK[15:8])
                     | (RESET_VALUE[15:8] & ~WRITE_MASK[15:8]);
      end
    end
  end
endmodule

//--- tb/acgc_config_bank_sva.sv
// Timing and field checks on the configuration bank ports.
`timescale 1ns/1ps
module acgc_config_bank_sva (
  input logic i_clk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, // Clock, reset, bus.
  input logic [5:0] i_wb_adr, input logic [3:0] i_wb_sel, // Address, lanes.
  input logic [31:0] i_wb_dat, o_wb_dat, input logic o_wb_ack, // Data, ack.
  input logic o_second_channel_enable, o_first_channel_enable, o_clock_source_external,
  input logic [2:0] o_oversampling_ratio_code, input logic [1:0] o_power_mode_code,
  input logic [2:0] o_second_channel_gain_code, o_first_channel_gain_code,
  input logic o_chop_enable, input logic [3:0] o_chop_delay_code);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // A request is taken only while ack is low, so held cycles do not count twice.
  wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire wr = req && i_wb_we;
  wire [3:0] idx = i_wb_adr[5:2];
  ack_timing_a: assert property (req |=> o_wb_ack) else $error("ack late");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  upper_zero_a: assert property (o_wb_dat[31:16] == 16'h0000) else $error("upper not zero");
  clk_ro_a: assert property (req && !i_wb_we && idx == 4'h3 |=> o_wb_dat[15:10] == 6'h00)
    else $error("clock top bits set");
  chan_en_a: assert property (wr && idx == 4'h3 && i_wb_sel[1] |=>
    {o_second_channel_enable, o_first_channel_enable} == $past(i_wb_dat[9:8]))
    else $error("channel enables wrong");
  clk_low_a: assert property (wr && idx == 4'h3 && i_wb_sel[0] |=>
    {o_clock_source_external, o_oversampling_ratio_code, o_power_mode_code}
    == {$past(i_wb_dat[7]), $past(i_wb_dat[4:0])}) else $error("clock fields wrong");
  gain_set_a: assert property (wr && idx == 4'h4 && i_wb_sel[0] |=>
    {o_second_channel_gain_code, o_first_channel_gain_code}
    == {$past(i_wb_dat[6:4]), $past(i_wb_dat[2:0])}) else $error("gain codes wrong");
  chop_set_a: assert property (wr && idx == 4'h6 && i_wb_sel[1] |=>
    {o_chop_delay_code, o_chop_enable} == $past(i_wb_dat[12:8])) else $error("chop wrong");
  fields_hold_a: assert property (!wr |=> $stable({o_second_channel_enable,
    o_first_channel_enable, o_clock_source_external, o_oversampling_ratio_code,
    o_power_mode_code, o_second_channel_gain_code, o_first_channel_gain_code,
    o_chop_enable, o_chop_delay_code})) else $error("field moved without write");
endmodule

//--- tb/acgc_host.sv
// Host model that issues classic single Wishbone cycles.
`timescale 1ns/1ps
module acgc_host (
  input logic i_clk, i_ack, input logic [31:0] i_dat, // Clock and answer.
  output logic o_cyc = '0, o_stb = '0, o_we = '0, // Cycle, strobe, direction.
  output logic [5:0] o_adr = '0, output logic [3:0] o_sel = '0, output logic [31:0] o_dat = '0);
  // Bits the host lets through in each word, all others sent as zero; read-only clock bits pass on purpose.
  function automatic logic [15:0] hm(input logic [3:0] i);
    case (i)
      4'h3: return 16'hff9f;
      4'h4: return 16'h0077;
      4'h6: return 16'h1f00;
      4'h5, 4'h7: return 16'h0000;
      default: return 16'hffff;
    endcase
  endfunction
  // One cycle: hold everything until ack is sampled high, then release.
  task automatic xfer(input logic w, input logic [5:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'b11, w, a, s, d};
    do @(posedge i_clk); while (i_ack !== 1'b1);
    q = i_dat;
    {o_cyc, o_stb} <= 2'b00;
    o_dat <= ~d; // A released data bus shows no stale value.
  endtask
  task automatic wr(input logic [5:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, s, {d[31:16], d[15:0] & hm(a[5:2])}, q);
  endtask
endmodule

//--- tb/tb.sv
// Random and corner-case register traffic against the configuration bank.
`timescale 1ns/1ps
module tb;
  logic i_clk = 0, i_rst_n = 0, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack; // Clock, reset, bus.
  logic [5:0] i_wb_adr; logic [3:0] i_wb_sel; logic [31:0] i_wb_dat, o_wb_dat, q;
  logic o_second_channel_enable, o_first_channel_enable, o_clock_source_external, o_chop_enable;
  logic [2:0] o_oversampling_ratio_code, o_second_channel_gain_code, o_first_channel_gain_code;
  logic [1:0] o_power_mode_code; logic [3:0] o_chop_delay_code;
  logic [15:0] e [16]; // Expected content of every word index.
  int bad_count = 0, n_tests = 0;
  always #5 i_clk = ~i_clk; // 100 MHz.
  acgc_config_bank dut (.*);
  acgc_host host (.i_clk, .i_ack(o_wb_ack), .i_dat(o_wb_dat), .o_cyc(i_wb_cyc),
    .o_stb(i_wb_stb), .o_we(i_wb_we), .o_adr(i_wb_adr), .o_sel(i_wb_sel), .o_dat(i_wb_dat));
  // Bits that survive a host write; spares and unmapped words keep zero.
  function automatic logic [15:0] keep(input logic [3:0] i);
    case (i)
      4'h3: return 16'h039f;
      4'h4: return 16'h0077;
      4'h6: return 16'h1f00;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      bad_count++;
      $display("ERROR %0t read %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_out();
    n_tests++;
    if ({o_second_channel_enable, o_first_channel_enable, o_clock_source_external,
        o_oversampling_ratio_code, o_power_mode_code, o_second_channel_gain_code,
        o_first_channel_gain_code, o_chop_delay_code, o_chop_enable} !== {e[3][9:7],
        e[3][4:0], e[4][6:4], e[4][2:0], e[6][12:8]}) begin
      bad_count++;
      $display("ERROR %0t field outputs differ", $time);
    end
  endtask
  task automatic complete_run;
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Write one word through chosen lanes, then check outputs and read back.
  task automatic touch(input logic [3:0] i, input logic [3:0] s, input logic [15:0] d);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}} & keep(i);
    host.wr({i, 2'b00}, s, {d, d});
    e[i] = (e[i] & ~m) | (d & m);
    chk_out();
    host.xfer(1'b0, {i, 2'b00}, 4'hf, 32'h00000000, q);
    chk_rd(q, {16'h0000, e[i]});
  endtask
  initial begin
    void'($urandom(32'hc851cb15));
    e = '{default: 16'h0000};
    e[3] = 16'h038e;
    e[6] = 16'h0600;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    chk_out();
    for (int i = 0; i < 16; i++) begin
      host.xfer(1'b0, 6'(i * 4), 4'hf, 32'h00000000, q);
      chk_rd(q, {16'h0000, e[i]});
    end
    touch(4'h3, 4'h3, 16'hffff);
    touch(4'h3, 4'h2, 16'h0000);
    touch(4'h6, 4'h3, 16'hffff);
    touch(4'h4, 4'h1, 16'hffff);
    repeat (90) touch(4'($urandom_range(2, 8)), 4'($urandom), 16'($urandom));
    // A second reset in mid-run must bring every word back to its reset value.
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    e = '{default: 16'h0000};
    e[3] = 16'h038e;
    e[6] = 16'h0600;
    chk_out();
    for (int i = 3; i < 8; i++) begin
      host.xfer(1'b0, 6'(i * 4), 4'hf, 32'h00000000, q);
      chk_rd(q, {16'h0000, e[i]});
    end
    complete_run;
  end
  // A hung handshake ends the run as a mismatch.
  initial begin
    #50000;
    bad_count++;
    complete_run;
  end
endmodule
bind acgc_config_bank acgc_config_bank_sva chk (.*);
